// ==== hw/ucir_channel.v ====
// Channel data ports, interrupt mask and prioritised identification over AHB-Lite
//
// Functional notes
// - offset zero reads receive, writes transmit
// - data ports untouched by master reset
// - each enabled source drives interrupt alone
// - masked sources never pending nor interrupting
// - status tracking runs regardless of mask, except CTS/RTS rise (mask bits 7:6)
// - CTS rising edge interrupt when enhanced
// - RTS rising edge interrupt when enhanced
// - stop character interrupt when enhanced
// - mask bit 4 sleeps only when enhanced
// - mask bit 3 enables modem status interrupt
// - line status bits 4:1 raise interrupt
// - mask bit 1 enables transmit empty
// - mask bit 0 enables data and timeout
// - seven levels, report only highest
// - identification read freezes indication
// - new events recorded during frozen read
// - bits 7:6 mirror queue enable
// - bit 5 flags RTS/CTS rise
// - bit 4 flags stop/special character
// - bits 3:1 name source, default 000
// - bit 0 low while interrupt pending
// - fixed six-bit codes per priority
// - transmit empty cleared by ident read or data write
// - timeout after 4 chars plus 12 bits
//
// Our own choice: the AHB-Lite interface to the registers.
`include "ucir_regs.vh"
module ucir_channel #(
  parameter TO_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hclken,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire cts_pin,
  input wire rts_level,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire [3:0] rx_err,
  input wire rx_overrun,
  input wire rx_stop_char,
  input wire rx_resume_char,
  input wire tx_empty,
  input wire msr_change,
  input wire msr_read,
  input wire lsr_read,
  input wire bit_tick,
  output reg rx_pop,
  output reg tx_push,
  output reg [7:0] tx_data,
  output reg sleep_mode,
  output reg interrupt_output
);
  reg [7:0] interrupt_mask;
  reg [7:0] ctrl;
  reg [7:0] receive_data_port;
  reg ap_valid;
  reg ap_write;
  reg [7:0] ap_addr;
  reg [7:0] ident_frozen;
  reg freeze;
  reg lsr_flag;
  reg txe_flag;
  reg msr_flag;
  reg xoff_flag;
  reg flow_flag;
  reg cts_prev;
  reg rts_prev;
  reg rx_err_pend;
  reg tx_empty_q;
  reg [5:0] next_code;
  reg [31:0] next_rdata;
  wire cts_level;
  wire to_flag;
  wire enh;
  wire qen;
  wire ap_take;
  wire rd_data;
  wire rd_ident;
  wire wr_data;
  wire [7:0] ident_live;
  wire [7:0] ident_now;
  wire [TO_W-1:0] to_limit;
  wire cts_rise;
  wire rts_rise;
  // Total idle bit times; cut to the counter width on purpose
  localparam [31:0] TO_TOTAL = `UCIR_TO_CHARS * `UCIR_BITS_PER_CHAR + `UCIR_TO_EXTRA_BITS;

  assign enh = ctrl[`UCIR_CTRL_ENH];
  assign qen = ctrl[`UCIR_CTRL_QEN];
  assign ap_take = hsel && hready && htrans[1];
  assign rd_data = ap_valid && !ap_write && ap_addr == `UCIR_OFF_DATA;
  assign rd_ident = ap_valid && !ap_write && ap_addr == `UCIR_OFF_IDENT;
  assign wr_data = ap_valid && ap_write && ap_addr == `UCIR_OFF_DATA;
  assign to_limit = TO_TOTAL[TO_W-1:0];
  assign cts_rise = cts_level && !cts_prev;
  assign rts_rise = rts_level && !rts_prev;

  ucir_sync u_cts (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hclken),
    .pin(cts_pin),
    .level(cts_level)
  );

  // Armed only in queued mode with data waiting
  ucir_timeout #(.W(TO_W)) u_to (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hclken),
    .bit_tick(bit_tick),
    .activity(rx_pop || !rx_valid),
    .armed(qen && rx_valid),
    .clear(rd_data),
    .limit(to_limit),
    .expired(to_flag)
  );

  // Priority encoder over enabled sources only
  always @* begin
    next_code = `UCIR_CODE_NONE;
    if (interrupt_mask[`UCIR_EN_LSR] && lsr_flag) begin
      next_code = `UCIR_CODE_LSR;
    end else if (interrupt_mask[`UCIR_EN_RXA] && to_flag) begin
      next_code = `UCIR_CODE_RTO;
    end else if (interrupt_mask[`UCIR_EN_RXA] && rx_valid) begin
      next_code = `UCIR_CODE_RXA;
    end else if (interrupt_mask[`UCIR_EN_TXE] && txe_flag) begin
      next_code = `UCIR_CODE_TXE;
    end else if (interrupt_mask[`UCIR_EN_MSR] && msr_flag) begin
      next_code = `UCIR_CODE_MSR;
    end else if (enh && interrupt_mask[`UCIR_EN_XOFF] && xoff_flag) begin
      next_code = `UCIR_CODE_XOFF;
    end else if (enh && (interrupt_mask[`UCIR_EN_CTS] || interrupt_mask[`UCIR_EN_RTS])
                 && flow_flag) begin
      next_code = `UCIR_CODE_FLOW;
    end
  end

  assign ident_live = {qen, qen, next_code};
  assign ident_now = freeze ? ident_frozen : ident_live;

  // Bus address phase capture, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else if (hclken) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_valid <= ap_take;
      if (ap_take) begin
        ap_write <= hwrite;
        ap_addr <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Read data chosen in the address phase so it stands in the data phase
  always @* begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == `UCIR_OFF_DATA) begin
      next_rdata = {24'h000000, receive_data_port};
    end else if (haddr[7:0] == `UCIR_OFF_MASK) begin
      next_rdata = {24'h000000, interrupt_mask};
    end else if (haddr[7:0] == `UCIR_OFF_IDENT) begin
      next_rdata = {24'h000000, ident_now};
    end else if (haddr[7:0] == `UCIR_OFF_CTRL) begin
      next_rdata = {24'h000000, ctrl};
    end else if (haddr[7:0] == `UCIR_OFF_STAT) begin
      next_rdata = {26'h0000000, rx_valid, tx_empty, lsr_flag, txe_flag, msr_flag, to_flag};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      freeze <= 1'b0;
      ident_frozen <= `UCIR_IDENT_RESET;
    end else if (hclken) begin
      if (ap_take && !hwrite) begin
        hrdata <= next_rdata;
      end
      // Snapshot held across the whole read access
      if (ap_take && !hwrite && haddr == `UCIR_OFF_IDENT) begin
        freeze <= 1'b1;
        ident_frozen <= ident_now;
      end else if (!ap_valid || ap_addr != `UCIR_OFF_IDENT || ap_write) begin
        freeze <= 1'b0;
        ident_frozen <= ident_live;
      end else begin
        freeze <= 1'b0;
      end
    end
  end

  // Control registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_mask <= `UCIR_MASK_RESET;
      ctrl <= 8'h00;
      sleep_mode <= 1'b0;
    end else if (hclken) begin
      if (ap_valid && ap_write && ap_addr == `UCIR_OFF_MASK) begin
        interrupt_mask <= hwdata[7:0];
      end
      if (ap_valid && ap_write && ap_addr == `UCIR_OFF_CTRL) begin
        ctrl <= hwdata[7:0];
      end
      sleep_mode <= enh && interrupt_mask[`UCIR_EN_SLEEP];
    end
  end

  // Data ports have no reset term; contents survive master reset
  always @(posedge hclk) begin
    if (hclken) begin
      if (rd_data) begin
        receive_data_port <= receive_data_port;
      end else begin
        receive_data_port <= rx_data;
      end
      if (wr_data) begin
        tx_data <= hwdata[7:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
    end else if (hclken) begin
      rx_pop <= rd_data && rx_valid;
      tx_push <= wr_data;
    end
  end

  // Edge history and the error tag of the byte at the queue head
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_prev <= 1'b0;
      rts_prev <= 1'b0;
      rx_err_pend <= 1'b0;
      // Low so an empty queue at reset counts as a fresh empty
      tx_empty_q <= 1'b0;
    end else if (hclken) begin
      cts_prev <= cts_level;
      rts_prev <= rts_level;
      rx_err_pend <= rx_valid && |rx_err[3:1];
      tx_empty_q <= tx_empty;
    end
  end

  // Sticky sources; a set always beats a clear in the same cycle
  // Overrun flags at once; other errors only as the byte is read out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsr_flag <= 1'b0;
    end else if (hclken) begin
      if (rx_overrun || (rd_data && rx_err_pend)) begin
        lsr_flag <= 1'b1;
      end else if (lsr_read) begin
        lsr_flag <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txe_flag <= 1'b0;
    end else if (hclken) begin
      if (tx_empty && !tx_empty_q) begin
        txe_flag <= 1'b1;
      end else if (wr_data || (rd_ident && ident_frozen[5:0] == `UCIR_CODE_TXE)) begin
        txe_flag <= 1'b0;
      end
    end
  end

  // Modem changes are tracked whether masked or not
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msr_flag <= 1'b0;
    end else if (hclken) begin
      if (msr_change) begin
        msr_flag <= 1'b1;
      end else if (msr_read) begin
        msr_flag <= 1'b0;
      end
    end
  end

  // Cleared by the resume character or by reading the report naming it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xoff_flag <= 1'b0;
    end else if (hclken) begin
      if (rx_stop_char) begin
        xoff_flag <= 1'b1;
      end else if (rx_resume_char || (rd_ident && ident_frozen[5:0] == `UCIR_CODE_XOFF)) begin
        xoff_flag <= 1'b0;
      end
    end
  end

  // Rise detectors count only for the enabled lines
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_flag <= 1'b0;
    end else if (hclken) begin
      if ((interrupt_mask[`UCIR_EN_CTS] && cts_rise) ||
          (interrupt_mask[`UCIR_EN_RTS] && rts_rise)) begin
        flow_flag <= 1'b1;
      end else if (msr_read || (rd_ident && ident_frozen[5:0] == `UCIR_CODE_FLOW)) begin
        flow_flag <= 1'b0;
      end
    end
  end

  // Pin follows the live report, not the copy frozen for a read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_output <= 1'b0;
    end else if (hclken) begin
      interrupt_output <= !ident_live[0];
    end
  end
endmodule // ucir_channel

// ==== hw/ucir_regs.vh ====
// Register offsets, field positions and timing counts for the channel register block
`ifndef UCIR_REGS_VH
`define UCIR_REGS_VH
`define UCIR_IDX_DATA 3'h0
`define UCIR_IDX_MASK 3'h1
`define UCIR_IDX_IDENT 3'h2
`define UCIR_IDX_CTRL 3'h3
`define UCIR_IDX_STAT 3'h4
`define UCIR_OFF_DATA 8'h00
`define UCIR_OFF_MASK 8'h04
`define UCIR_OFF_IDENT 8'h08
`define UCIR_OFF_CTRL 8'h0c
`define UCIR_OFF_STAT 8'h10
`define UCIR_MASK_RESET 8'h00
`define UCIR_IDENT_RESET 8'h01
`define UCIR_EN_CTS 7
`define UCIR_EN_RTS 6
`define UCIR_EN_XOFF 5
`define UCIR_EN_SLEEP 4
`define UCIR_EN_MSR 3
`define UCIR_EN_LSR 2
`define UCIR_EN_TXE 1
`define UCIR_EN_RXA 0
`define UCIR_CTRL_ENH 4
`define UCIR_CTRL_QEN 0
`define UCIR_CODE_LSR 6'h06
`define UCIR_CODE_RTO 6'h0c
`define UCIR_CODE_RXA 6'h04
`define UCIR_CODE_TXE 6'h02
`define UCIR_CODE_MSR 6'h00
`define UCIR_CODE_XOFF 6'h10
`define UCIR_CODE_FLOW 6'h20
`define UCIR_CODE_NONE 6'h01
`define UCIR_TO_CHARS 4
`define UCIR_TO_EXTRA_BITS 12
`define UCIR_BITS_PER_CHAR 10
`endif

// ==== hw/ucir_sync.v ====
// Three-stage synchroniser with agreement filter for one pin
module ucir_sync (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire pin,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // ucir_sync

// ==== hw/ucir_timeout.v ====
// Receive idle timer: fires after a set number of bit ticks without queue activity
module ucir_timeout #(
  parameter W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire bit_tick,
  input wire activity,
  input wire armed,
  input wire clear,
  input wire [W-1:0] limit,
  output reg expired
);
  reg [W-1:0] count;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {W{1'b0}};
      expired <= 1'b0;
    end else if (ce) begin
      if (activity || !armed) begin
        count <= {W{1'b0}};
      end else if (bit_tick && count != limit) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
      // An expiry in the same cycle as a clear wins, so no timeout is lost
      if (armed && bit_tick && !activity && count == limit - {{(W-1){1'b0}}, 1'b1}) begin
        expired <= 1'b1;
      end else if (clear || !armed) begin
        expired <= 1'b0;
      end
    end
  end
endmodule // ucir_timeout

// ==== tb/ucir_channel_properties.sv ====
// Port-level assertions for the channel register block
module ucir_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire rx_valid,
  input wire rx_pop,
  input wire tx_push,
  input wire [7:0] tx_data,
  input wire interrupt_output
);
  timeunit 1ns;
  timeprecision 1ps;
  wire tk = hsel && hready && htrans[1];
  wire rd0 = tk && !hwrite && haddr == 8'h00;
  wire wr0 = tk && hwrite && haddr == 8'h00;
  wire rdi = tk && !hwrite && haddr == 8'h08;
  wire [7:0] wd = hwdata[7:0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_pop_read: assert property (rd0 ##1 rx_valid |=> rx_pop)
    else $error("no pop");
  chk_pop_cause: assert property (rx_pop |-> $past(rd0, 2))
    else $error("stray pop");
  chk_push_data: assert property (wr0 |-> ##2 tx_push && tx_data == $past(wd))
    else $error("bad push");
  chk_push_cause: assert property (tx_push |-> $past(wr0, 2))
    else $error("stray push");
  chk_zero_wait: assert property (tk |=> hreadyout)
    else $error("wait state");
  chk_rdata_hold: assert property (!(tk && !hwrite) |=> $stable(hrdata))
    else $error("data moved");
  chk_irq_ident: assert property (rdi |=> hrdata[0] == !interrupt_output)
    else $error("irq vs ident");
  chk_ident_code: assert property (rdi |=> hrdata[5:0] inside {6'h06, 6'h0c, 6'h04,
    6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("bad code");
  cover property (rdi ##1 interrupt_output);
  cover property (wr0 ##2 tx_push);
  cover property (rd0 ##2 rx_pop);
endmodule // ucir_props
bind ucir_channel ucir_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .rx_valid, .rx_pop, .tx_push, .tx_data, .interrupt_output);

// ==== tb/ucir_far.sv ====
// Serial-side stand-in: receive queue, transmit drain and bit ticks
module ucir_far #(
  parameter DRAIN = 6
) (
  input wire hclk,
  input wire rx_pop,
  input wire tx_push,
  input wire load,
  input wire [7:0] load_byte,
  output logic rx_valid,
  output logic tx_empty,
  output logic bit_tick,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  int busy = 0;
  initial {rx_valid, tx_empty, bit_tick, rx_data} = 11'h200;
  always @(posedge hclk) begin
    bit_tick <= !bit_tick;
    if (load)
      q.push_back(load_byte);
    if (rx_pop && q.size() > 0)
      void'(q.pop_front());
    rx_valid <= q.size() > 0;
    // Empty queue shows a moving pattern: each cycle inverts the last byte, so it reappears every other cycle
    rx_data <= q.size() > 0 ? q[0] : ~rx_data;
    if (tx_push)
      busy = DRAIN;
    else if (busy > 0)
      busy--;
    tx_empty <= busy == 0;
  end
endmodule // ucir_far

// ==== tb/tb_top.sv ====
// Self-checking bench for the channel register block
`include "ucir_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, load = 0, rd_pend = 0;
  logic cts_pin = 0, rts_level = 0, rx_stop_char = 0, rx_overrun = 0, rx_resume_char = 0;
  logic [3:0] rx_err = 4'h0;
  logic [7:0] tx_keep = 8'h00;
  logic msr_change = 0, msr_read = 0, lsr_read = 0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00, load_byte = 8'h00, seed = 8'h97;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] expq[$];
  logic [7:0] txq[$];
  int num_errors = 0, tests_run = 0;
  wire [31:0] hrdata;
  wire [7:0] rx_data, tx_data;
  wire hreadyout, hresp, rx_valid, tx_empty, bit_tick, rx_pop, tx_push, sleep_mode, irq;
  ucir_channel dut (.hclk, .hresetn, .hclken(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cts_pin,
    .rts_level, .rx_valid, .rx_data, .rx_err, .rx_overrun, .rx_stop_char,
    .rx_resume_char, .tx_empty, .msr_change, .msr_read, .lsr_read, .bit_tick,
    .rx_pop, .tx_push, .tx_data, .sleep_mode, .interrupt_output(irq));
  ucir_far far (.hclk, .rx_pop, .tx_push, .load, .load_byte, .rx_valid, .tx_empty,
    .bit_tick, .rx_data);
  initial forever #4 hclk = ~hclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for ready, sampled at the edge
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    {haddr, hwrite, htrans, hsel} <= {a, w, 2'h2, 1'b1};
    hold;
    {htrans, hwdata} <= {2'h0, d};
    hold;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // One-cycle strobes: resume, stop, modem change, overrun, line read, modem read
  task automatic pulse(input logic [5:0] m);
    @(posedge hclk);
    {rx_resume_char, rx_stop_char, msr_change, rx_overrun, lsr_read, msr_read} <= m;
    @(posedge hclk);
    {rx_resume_char, rx_stop_char, msr_change, rx_overrun, lsr_read, msr_read} <= 6'h00;
  endtask
  always @(posedge hclk) begin
    if (rd_pend && hreadyout) begin
      chk(hrdata, expq.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
    if (tx_push)
      chk({24'h0, tx_data}, {24'h0, txq.pop_front()});
    rd_pend <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(`UCIR_OFF_MASK, 32'h0);
    rd(`UCIR_OFF_IDENT, 32'h1);
    bus(8'h1c, 1'b1, 32'hff);
    rd(8'h1c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(`UCIR_OFF_MASK, 1'b1, {24'h0, seed & 8'hef});
      rd(`UCIR_OFF_MASK, {24'h0, seed & 8'hef});
    end
    $display("done reset and mask");
    bus(`UCIR_OFF_MASK, 1'b1, 32'h10);
    repeat (2) @(posedge hclk);
    chk({31'h0, sleep_mode}, 32'h0);
    bus(`UCIR_OFF_CTRL, 1'b1, 32'h11);
    repeat (2) @(posedge hclk);
    chk({31'h0, sleep_mode}, 32'h1);
    bus(`UCIR_OFF_MASK, 1'b1, 32'h02);
    seed = lfsr(seed);
    txq.push_back(seed);
    tx_keep = seed;
    bus(`UCIR_OFF_DATA, 1'b1, {24'h0, seed});
    repeat (12) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    rd(`UCIR_OFF_IDENT, 32'hc2);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    $display("done sleep and transmit");
    bus(`UCIR_OFF_MASK, 1'b1, 32'h0);
    seed = lfsr(seed);
    @(posedge hclk);
    {load, load_byte} <= {1'b1, seed};
    @(posedge hclk);
    load <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    chk({31'h0, irq}, 32'h0);
    rd(`UCIR_OFF_STAT, 32'h30);
    bus(`UCIR_OFF_MASK, 1'b1, 32'h01);
    rd(`UCIR_OFF_IDENT, 32'hc4);
    repeat (150) @(posedge hclk);
    rd(`UCIR_OFF_IDENT, 32'hcc);
    rd(`UCIR_OFF_DATA, {24'h0, seed});
    repeat (3) @(posedge hclk);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    $display("done receive");
    bus(`UCIR_OFF_MASK, 1'b1, 32'hec);
    rts_level <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(`UCIR_OFF_IDENT, 32'he0);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    cts_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(`UCIR_OFF_IDENT, 32'he0);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    pulse(6'h10);
    rd(`UCIR_OFF_IDENT, 32'hd0);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    pulse(6'h10);
    pulse(6'h20);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    pulse(6'h08);
    pulse(6'h04);
    rd(`UCIR_OFF_IDENT, 32'hc6);
    pulse(6'h02);
    rd(`UCIR_OFF_IDENT, 32'hc0);
    pulse(6'h01);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    seed = lfsr(seed);
    @(posedge hclk);
    {load, load_byte, rx_err} <= {1'b1, seed, 4'h2};
    @(posedge hclk);
    load <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(`UCIR_OFF_DATA, {24'h0, seed});
    rx_err <= 4'h0;
    rd(`UCIR_OFF_IDENT, 32'hc6);
    pulse(6'h02);
    rd(`UCIR_OFF_IDENT, 32'hc1);
    $display("done priority");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({24'h0, tx_data}, {24'h0, tx_keep});
    rd(`UCIR_OFF_MASK, 32'h0);
    rd(`UCIR_OFF_IDENT, 32'h1);
    $display("done second reset");
    wrap_up;
  end
endmodule // tb_top
